// ==== pcc_pkg.sv ====
`default_nettype none
package pcc_pkg;
	localparam logic [7:0] PCC_OFS_PRR = 8'h00;
	localparam logic [7:0] PCC_OFS_PER = 8'h04;
	localparam logic [7:0] PCC_OFS_AMP = 8'h08;
	localparam logic [7:0] PCC_OFS_ISEL = 8'h0c;
	localparam logic [7:0] PCC_OFS_MODE = 8'h10;
	localparam logic [7:0] PCC_OFS_FILT = 8'h14;
	// Register bit positions; AMP and CMP are shared by the peripheral reset and clock-enable registers
	localparam int PCC_B_AMP = 2;
	localparam int PCC_B_CMP = 5;
	localparam int PCC_B_AMP_EN = 7;
	localparam int PCC_B_FGND = 3;
	localparam int PCC_B_MON = 3;
	localparam int PCC_B_VRF = 2;
	localparam int PCC_B_WDE = 1;
	localparam int PCC_B_ENB = 0;
	localparam int PCC_B_EDG = 3;
	localparam int PCC_B_EPO = 2;
	localparam logic [7:0] PCC_PRR_MASK = 8'h24;
	localparam logic [7:0] PCC_PER_MASK = 8'h24;
	localparam logic [7:0] PCC_AMP_MASK = 8'h8b;
	localparam logic [7:0] PCC_ISEL_MASK = 8'h0f;
	localparam logic [7:0] PCC_MODE_MASK = 8'h07;
	localparam logic [7:0] PCC_FILT_MASK = 8'h0f;
	localparam logic [7:0] PCC_RST_PRR = 8'h00;
	localparam logic [7:0] PCC_RST_PER = 8'h00;
	localparam logic [7:0] PCC_RST_AMP = 8'h00;
	localparam logic [7:0] PCC_RST_ISEL = 8'h00;
	localparam logic [7:0] PCC_RST_MODE = 8'h00;
	localparam logic [7:0] PCC_RST_FILT = 8'h00;
	localparam logic [1:0] PCC_FILT_OFF = 2'h0;
	localparam logic [1:0] PCC_FILT_D1 = 2'h1;
	localparam logic [1:0] PCC_FILT_D8 = 2'h2;
	localparam logic [1:0] PCC_FILT_D32 = 2'h3;
	localparam logic [4:0] PCC_DIV8_LAST = 5'h07;
	localparam logic [4:0] PCC_DIV32_LAST = 5'h1f;
	localparam int PCC_FILT_AGREE = 3;
endpackage
`default_nettype wire

// ==== pcc_ctrl.sv ====
// Implementation choices: the register offsets and the AHB-Lite register port.
`default_nettype none
module pcc_ctrl import pcc_pkg::*; #(
	parameter int AGREE = PCC_FILT_AGREE
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cmp_result,
	output logic amp_reset,
	output logic amp_enable,
	output logic [3:0] amp_gain_sel,
	output logic amp_fb_ground_pin,
	output logic cmp_reset,
	output logic cmp_clock_on,
	output logic [2:0] cmp_pos_sel,
	output logic [2:0] cmp_neg_sel,
	output logic cmp_ref_bandgap,
	output logic cmp_window,
	output logic cmp_enable,
	output logic cmp_filtered,
	output logic cmp_irq
);
	// One-hot decode of a two-bit field; code 3 sets bit 3
	function automatic logic [3:0] dec2(input logic [1:0] f);
		dec2 = 4'h1 << f;
	endfunction

	logic dp_valid_r, dp_write_r, rd_wait_r;
	logic [7:0] dp_addr_r;
	logic [7:0] prr_r, per_r, amp_r, isel_r, mode_r, filt_r;
	logic cmp_in_r, filt_out_r, prev_r, irq_r;
	logic [4:0] div_r;
	localparam int AW = $clog2(AGREE + 1);
	logic [AW-1:0] agree_r;
	logic [3:0] pos_dec, neg_dec;
	logic addr_take, wr_now, amp_rst, amp_clk, cmp_rst, cmp_clk, cmp_on;
	logic strobe, edge_hit, rise, fall;
	logic [7:0] rd_mux, wbyte;

	assign addr_take = hsel && htrans[1] && hready;
	assign wr_now = dp_valid_r && dp_write_r;
	assign wbyte = hwdata[7:0];
	assign amp_rst = prr_r[PCC_B_AMP];
	assign amp_clk = per_r[PCC_B_AMP];
	assign cmp_rst = prr_r[PCC_B_CMP];
	assign cmp_clk = per_r[PCC_B_CMP];
	assign cmp_on = mode_r[PCC_B_ENB] && cmp_clk && !cmp_rst;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else if (hready) begin
			dp_valid_r <= addr_take;
			dp_write_r <= hwrite;
			dp_addr_r <= {haddr[7:2], 2'b00};
		end
	end

	// Reads take one wait state so that hrdata comes from a flop and sees
	// a write made in the cycle just before
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_r <= 1'b0;
		end else begin
			rd_wait_r <= dp_valid_r && !dp_write_r && !rd_wait_r;
		end
	end

	assign hreadyout = !(dp_valid_r && !dp_write_r && !rd_wait_r);
	assign hresp = 1'b0;

	always_comb begin
		rd_mux = 8'h00;
		unique case (dp_addr_r)
			PCC_OFS_PRR: rd_mux = prr_r;
			PCC_OFS_PER: rd_mux = per_r;
			PCC_OFS_AMP: rd_mux = amp_clk ? amp_r : 8'h00;
			PCC_OFS_ISEL: rd_mux = isel_r;
			PCC_OFS_MODE: rd_mux = mode_r | {4'h0, cmp_on && cmp_in_r, 3'h0};
			PCC_OFS_FILT: rd_mux = filt_r;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (dp_valid_r && !dp_write_r && !rd_wait_r) begin
			hrdata <= {24'h00_0000, rd_mux};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prr_r <= PCC_RST_PRR;
			per_r <= PCC_RST_PER;
		end else if (wr_now) begin
			if (dp_addr_r == PCC_OFS_PRR) begin
				prr_r <= wbyte & PCC_PRR_MASK;
			end
			if (dp_addr_r == PCC_OFS_PER) begin
				per_r <= wbyte & PCC_PER_MASK;
			end
		end
	end

	// Amplifier register: cleared in reset only while its clock is on, frozen without its clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			amp_r <= PCC_RST_AMP;
		end else if (amp_rst && amp_clk) begin
			amp_r <= PCC_RST_AMP;
		end else if (wr_now && amp_clk && dp_addr_r == PCC_OFS_AMP) begin
			amp_r <= wbyte & PCC_AMP_MASK;
		end
	end

	// Comparator registers share the peripheral reset and clock gate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			isel_r <= PCC_RST_ISEL;
			mode_r <= PCC_RST_MODE;
			filt_r <= PCC_RST_FILT;
		end else if (cmp_rst) begin
			isel_r <= PCC_RST_ISEL;
			mode_r <= PCC_RST_MODE;
			filt_r <= PCC_RST_FILT;
		end else if (wr_now && cmp_clk) begin
			if (dp_addr_r == PCC_OFS_ISEL) begin
				isel_r <= wbyte & PCC_ISEL_MASK;
			end
			if (dp_addr_r == PCC_OFS_MODE) begin
				mode_r <= wbyte & PCC_MODE_MASK;
			end
			if (dp_addr_r == PCC_OFS_FILT) begin
				filt_r <= wbyte & PCC_FILT_MASK;
			end
		end
	end

	// Analog-facing controls
	assign amp_reset = amp_rst;
	assign amp_enable = amp_r[PCC_B_AMP_EN] && !amp_rst && amp_clk;
	assign amp_gain_sel = dec2(amp_r[1:0]);
	assign amp_fb_ground_pin = amp_r[PCC_B_FGND];
	assign cmp_reset = cmp_rst;
	assign cmp_clock_on = cmp_clk;
	// The forbidden code 3 connects nothing rather than two sources at once
	assign pos_dec = dec2(isel_r[3:2]);
	assign neg_dec = dec2(isel_r[1:0]);
	assign cmp_pos_sel = pos_dec[2:0] & 3'h6;
	assign cmp_neg_sel = neg_dec[2:0] & 3'h6;
	assign cmp_ref_bandgap = mode_r[PCC_B_VRF];
	assign cmp_window = mode_r[PCC_B_WDE];
	assign cmp_enable = cmp_on;

	// The comparator result is already a window/standard decision from the
	// analog side, so one sampling flop is all the digital path needs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_in_r <= 1'b0;
		end else begin
			cmp_in_r <= cmp_result;
		end
	end

	// Sampling prescaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 5'h00;
		end else begin
			div_r <= div_r + 5'h01;
		end
	end

	always_comb begin
		strobe = 1'b0;
		unique case (filt_r[1:0])
			PCC_FILT_OFF: strobe = 1'b1;
			PCC_FILT_D1: strobe = 1'b1;
			PCC_FILT_D8: strobe = (div_r[2:0] == PCC_DIV8_LAST[2:0]);
			PCC_FILT_D32: strobe = (div_r == PCC_DIV32_LAST);
		endcase
	end

	// Majority-free agreement filter: a new level must repeat AGREE times
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_out_r <= 1'b0;
			agree_r <= '0;
		end else if (!cmp_on) begin
			filt_out_r <= cmp_in_r;
			agree_r <= '0;
		end else if (filt_r[1:0] == PCC_FILT_OFF) begin
			filt_out_r <= cmp_in_r;
			agree_r <= '0;
		end else if (strobe) begin
			if (cmp_in_r == filt_out_r) begin
				agree_r <= '0;
			end else if (agree_r == AW'(AGREE - 1)) begin
				filt_out_r <= cmp_in_r;
				agree_r <= '0;
			end else begin
				agree_r <= agree_r + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= filt_out_r;
		end
	end

	assign rise = filt_out_r && !prev_r;
	assign fall = !filt_out_r && prev_r;
	always_comb begin
		if (filt_r[PCC_B_EDG]) begin
			edge_hit = rise || fall;
		end else begin
			edge_hit = filt_r[PCC_B_EPO] ? fall : rise;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= edge_hit && cmp_on;
		end
	end

	assign cmp_irq = irq_r;
	assign cmp_filtered = filt_out_r;

	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_write(logic [7:0] ofs);
		wr_now && dp_addr_r == ofs;
	endsequence

	sequence s_rd_cap(logic [7:0] ofs);
		dp_valid_r && !dp_write_r && !rd_wait_r && dp_addr_r == ofs;
	endsequence

	sequence s_rise_seen;
		filt_out_r && !prev_r;
	endsequence

	sequence s_fall_seen;
		!filt_out_r && prev_r;
	endsequence

	a_amp_reset_follow: assert property (
		s_write(PCC_OFS_PRR) ##0 wbyte[PCC_B_AMP] |=> amp_reset ##1 (amp_r == PCC_RST_AMP
			|| !amp_clk))
		else $error("amplifier reset not applied");
	a_amp_clear: assert property (
		amp_rst && amp_clk |=> amp_r == PCC_RST_AMP)
		else $error("amplifier register not cleared in reset");
	a_amp_hold_reset: assert property (
		amp_reset |-> !amp_enable)
		else $error("amplifier enabled while in reset");
	a_amp_write_blocked: assert property (
		s_write(PCC_OFS_AMP) ##0 !amp_clk |=> $stable(amp_r))
		else $error("amplifier write taken without clock");
	a_amp_write_taken: assert property (
		s_write(PCC_OFS_AMP) ##0 amp_clk && !amp_rst |=> amp_r == ($past(wbyte) & PCC_AMP_MASK))
		else $error("amplifier write lost");
	a_fb_ground_map: assert property (
		s_write(PCC_OFS_AMP) ##0 amp_clk && !amp_rst
			|=> amp_fb_ground_pin == $past(wbyte[PCC_B_FGND]))
		else $error("feedback ground not following write");
	a_gain_x8: assert property (
		amp_r[1:0] == 2'h1 |-> amp_gain_sel == 4'h2)
		else $error("x8 gain not decoded");
	a_gain_x16: assert property (
		amp_r[1:0] == 2'h2 |-> amp_gain_sel == 4'h4)
		else $error("x16 gain not decoded");
	a_cmp_clock_follow: assert property (
		s_write(PCC_OFS_PER) |=> cmp_clock_on == $past(wbyte[PCC_B_CMP]))
		else $error("comparator clock not following write");
	a_cmp_write_blocked: assert property (
		s_write(PCC_OFS_MODE) ##0 !cmp_clk && !cmp_rst |=> $stable(mode_r))
		else $error("comparator write taken without clock");
	a_isel_reset: assert property (
		cmp_rst |=> isel_r == PCC_RST_ISEL)
		else $error("input select not held in reset");
	a_pos_pin: assert property (
		isel_r[3:2] == 2'h1 |-> cmp_pos_sel == 3'h2)
		else $error("positive input pin not selected");
	a_pos_amp: assert property (
		isel_r[3:2] == 2'h2 |-> cmp_pos_sel == 3'h4)
		else $error("amplifier output not selected");
	a_neg_pin: assert property (
		isel_r[1:0] == 2'h1 |-> cmp_neg_sel == 3'h2)
		else $error("reference pin not selected");
	a_neg_dac: assert property (
		isel_r[1:0] == 2'h2 |-> cmp_neg_sel == 3'h4)
		else $error("converter channel not selected");
	a_neg_forbidden: assert property (
		isel_r[1:0] == 2'h3 |-> cmp_neg_sel == 3'h0)
		else $error("forbidden negative select drives a source");
	a_ref_select: assert property (
		s_write(PCC_OFS_MODE) ##0 cmp_clk && !cmp_rst
			|=> cmp_ref_bandgap == $past(wbyte[PCC_B_VRF]))
		else $error("reference select not following write");
	a_window_select: assert property (
		s_write(PCC_OFS_MODE) ##0 cmp_clk && !cmp_rst
			|=> cmp_window == $past(wbyte[PCC_B_WDE]))
		else $error("window mode not following write");
	a_monitor_read: assert property (
		s_rd_cap(PCC_OFS_MODE) |=> hrdata[PCC_B_MON] == $past(cmp_on && cmp_in_r))
		else $error("monitor flag read wrong");
	a_monitor_off: assert property (
		s_rd_cap(PCC_OFS_MODE) ##0 !cmp_on |=> !hrdata[PCC_B_MON])
		else $error("monitor flag set while disabled");
	a_both_fall: assert property (
		s_fall_seen ##0 cmp_on && filt_r[PCC_B_EDG] |=> cmp_irq)
		else $error("falling edge missed in both-edge mode");
	a_fall_taken: assert property (
		s_fall_seen ##0 cmp_on && !filt_r[PCC_B_EDG] && filt_r[PCC_B_EPO] |=> cmp_irq)
		else $error("falling edge missed");
	a_rise_taken: assert property (
		s_rise_seen ##0 cmp_on && !filt_r[PCC_B_EDG] && !filt_r[PCC_B_EPO] |=> cmp_irq)
		else $error("rising edge missed");
	a_no_fall_req: assert property (
		s_fall_seen ##0 !filt_r[PCC_B_EDG] && !filt_r[PCC_B_EPO] |=> !cmp_irq)
		else $error("falling edge raised request in rising mode");
	a_no_filter_pass: assert property (
		cmp_on && filt_r[1:0] == PCC_FILT_OFF |=> cmp_filtered == $past(cmp_in_r))
		else $error("unfiltered path delayed");
	a_div32_spacing: assert property (
		strobe && filt_r[1:0] == PCC_FILT_D32 |=> (!strobe || filt_r[1:0] != PCC_FILT_D32) [*8])
		else $error("divide-by-32 sample spacing broken");
	a_filter_hold: assert property (
		cmp_on && filt_r[1:0] != PCC_FILT_OFF && !strobe |=> $stable(cmp_filtered))
		else $error("filtered output moved between samples");
	a_disabled_quiet: assert property (
		!cmp_on |=> !cmp_irq)
		else $error("request raised while disabled");
	a_amp_run_gate: assert property (
		amp_enable |-> amp_r[PCC_B_AMP_EN] && !amp_reset)
		else $error("amplifier running while disabled");
	a_gain_decode: assert property (
		amp_r[1:0] == 2'h3 |-> amp_gain_sel == 4'h8)
		else $error("x32 gain not decoded");
	a_pos_forbidden: assert property (
		isel_r[3:2] == 2'h3 |-> cmp_pos_sel == 3'h0)
		else $error("forbidden positive select drives a source");
	a_cmp_reset_clear: assert property (
		cmp_rst |=> mode_r == PCC_RST_MODE && filt_r == PCC_RST_FILT)
		else $error("comparator registers not held in reset");
	a_irq_needs_enable: assert property (
		cmp_irq |-> $past(cmp_on))
		else $error("request while comparator disabled");
	a_rise_only: assert property (
		cmp_irq && !$past(filt_r[PCC_B_EDG]) && !$past(filt_r[PCC_B_EPO])
			|-> $past(filt_out_r) && !$past(prev_r))
		else $error("request without rising edge");
	a_div8_spacing: assert property (
		strobe && filt_r[1:0] == PCC_FILT_D8 |=> (!strobe || filt_r[1:0] != PCC_FILT_D8) [*7])
		else $error("divide-by-8 sample spacing broken");
	a_filter_agree: assert property (
		cmp_on && filt_r[1:0] == PCC_FILT_D1 && $past(cmp_on)
			&& $past(filt_r[1:0]) == PCC_FILT_D1 && $changed(filt_out_r)
			|-> $past(cmp_in_r, 1) == filt_out_r && $past(cmp_in_r, 3) == filt_out_r)
		else $error("filtered output changed without agreement");
	a_read_wait: assert property (
		addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state missing");
endmodule // pcc_ctrl
`default_nettype wire

// ==== pga_comparator_control_tb_top.sv ====
`default_nettype none
module pga_comparator_control_tb_top import pcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic cmp_result = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, amp_reset, amp_enable, amp_fb_ground_pin, cmp_reset;
	logic cmp_clock_on, cmp_ref_bandgap, cmp_window, cmp_enable, cmp_filtered, cmp_irq;
	logic [3:0] amp_gain_sel;
	logic [2:0] cmp_pos_sel, cmp_neg_sel;
	int miscompares = 0;
	int n_checks = 0;
	int nirq = 0;

	pcc_ctrl pcc_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmp_result, .amp_reset, .amp_enable,
		.amp_gain_sel, .amp_fb_ground_pin, .cmp_reset, .cmp_clock_on, .cmp_pos_sel, .cmp_neg_sel,
		.cmp_ref_bandgap, .cmp_window, .cmp_enable, .cmp_filtered, .cmp_irq);

	initial begin
		forever #2.5 hclk = ~hclk;
	end

	// Pulses are one cycle wide, so counting per edge gives the request count
	always @(posedge hclk) begin
		if (cmp_irq === 1'b1) nirq <= nirq + 1;
	end

	task automatic wrap_up;
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Ready and read data are taken at the rising edge, before its updates land
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 20) begin
			k++;
			@(posedge hclk);
		end
		if (k == 20) begin
			miscompares++;
			wrap_up();
		end else begin
			r = hrdata;
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
		@(negedge hclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(r, e);
	endtask

	task automatic hold(input logic v, input int n);
		@(posedge hclk);
		cmp_result <= v;
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask

	function automatic logic [2:0] exp_sel(input logic [1:0] c);
		// Forbidden code 11 must select nothing
		return (c == 2'h1 || c == 2'h2) ? 3'h1 << c : 3'h0;
	endfunction

	initial begin
		logic [31:0] d;
		int base;
		int p;
		void'($urandom(32'h8c4e14d9));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk(amp_gain_sel, 4'h1);
		for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), 32'h0);
		xfer(PCC_OFS_AMP, 1'b1, 32'h8b);
		rd_chk(PCC_OFS_AMP, 32'h0);
		wr(PCC_OFS_PER, 32'h24);
		chk(cmp_clock_on, 1'b1);
		for (int g = 0; g < 4; g++) begin
			d = $urandom;
			d[1:0] = 2'(g);
			wr(PCC_OFS_AMP, d);
			chk(amp_gain_sel, 4'h1 << g);
			chk(amp_fb_ground_pin, d[3]);
			chk(amp_enable, d[7]);
			rd_chk(PCC_OFS_AMP, d & PCC_AMP_MASK);
		end
		wr(PCC_OFS_AMP, 32'h80);
		wr(PCC_OFS_PRR, 32'h04);
		chk({amp_reset, amp_enable}, 2'h2);
		rd_chk(PCC_OFS_AMP, 32'h0);
		wr(PCC_OFS_PRR, 32'h00);
		for (int c = 0; c < 16; c++) begin
			wr(PCC_OFS_ISEL, c);
			chk(cmp_pos_sel, exp_sel(2'(c >> 2)));
			chk(cmp_neg_sel, exp_sel(2'(c)));
		end
		for (int m = 0; m < 8; m++) begin
			wr(PCC_OFS_MODE, m);
			chk(cmp_ref_bandgap, m[2]);
			chk(cmp_window, m[1]);
			chk(cmp_enable, m[0]);
			d = $urandom % 2;
			hold(d[0], 3);
			rd_chk(PCC_OFS_MODE, m | ((d & m[0]) << 3));
			hold(1'b0, 3);
		end
		wr(PCC_OFS_PRR, 32'h20);
		chk({cmp_reset, cmp_enable}, 2'h2);
		rd_chk(PCC_OFS_MODE, 32'h0);
		wr(PCC_OFS_PRR, 32'h00);
		wr(PCC_OFS_MODE, 32'h01);
		for (int e = 0; e < 4; e++) begin
			wr(PCC_OFS_FILT, e << 2);
			base = nirq;
			hold(1'b1, 8);
			chk(cmp_filtered, 1'b1);
			chk(32'(nirq - base), (e >= 2) ? 1 : (e == 0));
			hold(1'b0, 8);
			chk(32'(nirq - base), (e >= 2) ? 2 : 1);
		end
		for (int f = 1; f < 4; f++) begin
			p = (f == 1) ? 1 : (f == 2) ? 8 : 32;
			wr(PCC_OFS_FILT, f);
			base = nirq;
			// A glitch seen by at most two samples must be swallowed
			hold(1'b1, 2 * p - 1);
			hold(1'b0, 4 * p + 4);
			chk(cmp_filtered, 1'b0);
			chk(32'(nirq - base), 32'h0);
			hold(1'b1, 4 * p + 4);
			chk(cmp_filtered, 1'b1);
			chk(32'(nirq - base), 32'h1);
			hold(1'b0, 4 * p + 4);
		end
		wr(PCC_OFS_MODE, 32'h00);
		base = nirq;
		hold(1'b1, 8);
		hold(1'b0, 8);
		chk(32'(nirq - base), 32'h0);
		wrap_up();
	end
endmodule // pga_comparator_control_tb_top
`default_nettype wire
